// ### eps_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module eps_asserts #(
  parameter int PGM_PULSE_CYC = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Switches
  input wire logic mode_select_high,
  input wire logic mode_select_low,
  input wire logic restart_switch,
  // Sockets
  input wire logic [10:0] src_addr,
  input wire logic src_rd,
  input wire logic [11:0] tgt_addr,
  input wire logic [7:0] tgt_wdata,
  input wire logic tgt_data_oe,
  input wire logic tgt_rd,
  input wire logic tgt_pgm,
  // Indicators
  input wire logic led_blank,
  input wire logic led_program,
  input wire logic led_verify
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  int pgm_len;
  logic test_m;
  // Length of the current program pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pgm_len <= 0;
    end else begin
      pgm_len <= tgt_pgm ? pgm_len + 1 : 0;
    end
  end
  // Self test selected
  assign test_m = !mode_select_high && !mode_select_low;
  //////////////////////////////////////////////
  a_start_release: assert property (
    $fell(restart_switch) && !test_m |-> ##[1:3] (src_rd || tgt_rd))
    else $error("no read after restart release");
  a_dark_on_start: assert property (
    $fell(restart_switch) |-> ##3 !(led_blank || led_program || led_verify))
    else $error("indicator lit while running");
  a_tgt_offset: assert property (
    tgt_rd || tgt_pgm |-> tgt_addr == (src_addr[10] ?
      {1'h0, src_addr} + 12'h800 : {1'h0, src_addr}))
    else $error("target address not source plus offset");
  a_src_window: assert property (
    src_rd |-> (src_addr >= 11'h012 && src_addr <= 11'h05f) ||
      (src_addr >= 11'h400 && src_addr <= 11'h7f7) || src_addr >= 11'h7fc)
    else $error("source read outside image areas");
  a_pgm_drive: assert property (
    tgt_pgm |-> tgt_data_oe && !tgt_rd && mode_select_high && !mode_select_low)
    else $error("program pulse without drive or outside program mode");
  // Pulse spans the load, the timer start and the output register
  a_pgm_len: assert property (
    $fell(tgt_pgm) |-> pgm_len == PGM_PULSE_CYC + 2)
    else $error("program pulse length wrong");
  a_readback: assert property (
    $fell(tgt_pgm) |-> ##[1:16] tgt_rd)
    else $error("no readback after program pulse");
  a_test_walk: assert property (
    test_m && tgt_data_oe |-> $onehot(tgt_wdata))
    else $error("self test pattern not a single one");
  a_read_undriven: assert property (
    tgt_rd && !test_m |-> !tgt_data_oe)
    else $error("target driven during read");
  c_pulse: cover property ($rose(tgt_pgm));
  c_verify: cover property ($fell(restart_switch) && mode_select_high
    && mode_select_low);
  c_blank: cover property ($rose(led_blank));
endmodule

bind eps_sequencer eps_asserts #(.PGM_PULSE_CYC(PGM_PULSE_CYC))
  eps_asserts_inst (.pclk(pclk), .presetn(presetn),
  .mode_select_high(mode_select_high), .mode_select_low(mode_select_low),
  .restart_switch(restart_switch), .src_addr(src_addr), .src_rd(src_rd),
  .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_data_oe(tgt_data_oe),
  .tgt_rd(tgt_rd), .tgt_pgm(tgt_pgm), .led_blank(led_blank),
  .led_program(led_program), .led_verify(led_verify));

`default_nettype wire

// ### eps_pkg.sv
package eps_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ = 25000000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  // Per-byte programming pulse, typical figure
  localparam int PGM_PULSE_US = 5000;
  // Per-byte read settle, sized so a full verify pass takes about 4 s
  localparam int READ_SETTLE_US = 3600;
  // Half period of the fail blink, 4 Hz blink
  localparam int BLINK_HALF_MS = 125;
  // Self-test fault flash duration
  localparam int FAULT_FLASH_MS = 4000;
  localparam int PGM_PULSE_CYC = PGM_PULSE_US * CYC_PER_US;
  localparam int READ_SETTLE_CYC = READ_SETTLE_US * CYC_PER_US;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CYC_PER_US;
  localparam int FAULT_FLASH_CYC = FAULT_FLASH_MS * 1000 * CYC_PER_US;

  ////////////////////////////////////////////////////////////////////////////
  // Source image map
  localparam logic [10:0] ADDR_OPT_FIRST = 11'h012;
  localparam logic [10:0] ADDR_DATA_LAST = 11'h05f;
  localparam logic [10:0] ADDR_PROG_FIRST = 11'h400;
  localparam logic [10:0] ADDR_PROG_LAST = 11'h7f7;
  localparam logic [10:0] ADDR_VEC_FIRST = 11'h7fc;
  localparam logic [10:0] ADDR_LAST = 11'h7ff;
  localparam logic [11:0] TGT_PROG_OFFSET = 12'h800;
  localparam logic [7:0] BLANK_VALUE = 8'h00;
  localparam logic [7:0] TEST_SEED = 8'h01;
  localparam logic [2:0] TEST_LAST_STEP = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_CLR = 8'h0c;
  localparam logic [7:0] REG_INT_EN = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_FAIL_BIT = 1;
  localparam logic [1:0] INT_EN_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Modes, coded {mode_select_high, mode_select_low}
  typedef enum logic [1:0] {
    MODE_TEST = 2'b00,
    MODE_BLANK = 2'b01,
    MODE_PROG = 2'b10,
    MODE_VERIFY = 2'b11
  } eps_mode_t;

  // Sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_READ = 5'b00100,
    ST_PULSE = 5'b01000,
    ST_EVAL = 5'b10000
  } eps_state_t;

endpackage

// ### eps_sequencer.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none

module eps_sequencer #(
  parameter int PGM_PULSE_CYC = eps_pkg::PGM_PULSE_CYC,
  parameter int READ_SETTLE_CYC = eps_pkg::READ_SETTLE_CYC,
  parameter int BLINK_HALF_CYC = eps_pkg::BLINK_HALF_CYC,
  parameter int FAULT_FLASH_CYC = eps_pkg::FAULT_FLASH_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Operator switches
  input wire logic mode_select_high,
  input wire logic mode_select_low,
  input wire logic restart_switch,
  // Source EPROM
  output logic [10:0] src_addr,
  output logic src_rd,
  input wire logic [7:0] src_data,
  // Target socket
  output logic [11:0] tgt_addr,
  output logic [7:0] tgt_wdata,
  output logic tgt_data_oe,
  output logic tgt_rd,
  output logic tgt_pgm,
  input wire logic [7:0] tgt_rdata,
  // Indicators
  output logic led_blank,
  output logic led_program,
  output logic led_verify
);

  typedef struct packed {
    eps_pkg::eps_state_t state;
    eps_pkg::eps_mode_t mode;
    logic [10:0] addr;
    logic [2:0] step;
    logic written;
    logic fail;
    logic done;
    logic flash_on;
    logic blink;
    logic sw_prev;
    logic [1:0] int_stat;
    logic [1:0] int_en;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] wdata;
    logic rd;
    logic oe;
    logic pgm;
    logic [2:0] leds;
    logic tmr_start;
    logic [31:0] tmr_load;
  } eps_st_t;

  eps_st_t s_reg;
  eps_st_t s_next;

  eps_tmr_if step_tmr ();
  eps_tmr_if blink_tmr ();

  logic release_evt;
  logic sw_start;
  logic go;
  eps_pkg::eps_mode_t go_mode;
  logic apb_wr;
  logic apb_setup;
  logic [7:0] expect_byte;
  logic bad;
  logic last_addr;
  logic [10:0] addr_step;
  logic [1:0] ev;
  logic [1:0] clr;
  logic res_lit;

  ////////////////////////////////////////////////////////////////////////////
  // Byte timer and free running blink timer
  eps_timer u_step_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .t(step_tmr.tmr)
  );

  eps_timer u_blink_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .t(blink_tmr.tmr)
  );

  assign step_tmr.start = s_reg.tmr_start;
  assign step_tmr.load = s_reg.tmr_load;
  assign blink_tmr.start = !blink_tmr.busy;
  assign blink_tmr.load = 32'(BLINK_HALF_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Start sources and bus strobes
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign release_evt = s_reg.sw_prev && !restart_switch;
  assign sw_start = apb_wr && (paddr == eps_pkg::REG_CTRL) &&
                    pwdata[eps_pkg::CTRL_START_BIT];
  assign go = release_evt || sw_start;
  assign clr = (apb_wr && (paddr == eps_pkg::REG_INT_CLR)) ?
               pwdata[1:0] : 2'h0;

  // Mode decode, switch release wins over a software start
  always_comb begin
    if (release_evt) begin
      go_mode = eps_pkg::eps_mode_t'({mode_select_high,
                                      mode_select_low});
    end else begin
      go_mode = eps_pkg::eps_mode_t'(pwdata[eps_pkg::CTRL_MODE_LSB +: 2]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Walk over the image areas, skipping the gaps
  always_comb begin
    if (s_reg.addr == eps_pkg::ADDR_DATA_LAST) begin
      addr_step = eps_pkg::ADDR_PROG_FIRST;
    end else if (s_reg.addr == eps_pkg::ADDR_PROG_LAST) begin
      addr_step = eps_pkg::ADDR_VEC_FIRST;
    end else begin
      addr_step = 11'(s_reg.addr + 11'h001);
    end
  end

  assign last_addr = (s_reg.addr == eps_pkg::ADDR_LAST);

  // Byte expected back from the target in each mode
  always_comb begin
    unique case (s_reg.mode)
      eps_pkg::MODE_TEST: expect_byte = eps_pkg::TEST_SEED << s_reg.step;
      eps_pkg::MODE_BLANK: expect_byte = eps_pkg::BLANK_VALUE;
      eps_pkg::MODE_PROG: expect_byte = s_reg.wdata;
      eps_pkg::MODE_VERIFY: expect_byte = src_data;
    endcase
  end

  assign bad = (tgt_rdata != expect_byte);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, register file and indicators
  always_comb begin
    s_next = s_reg;
    s_next.tmr_start = 1'b0;
    s_next.sw_prev = restart_switch;
    ev = 2'h0;

    // Fault flash ends after its own time, blink phase toggles
    if (blink_tmr.expired) begin
      s_next.blink = !s_reg.blink;
    end
    if (s_reg.flash_on && step_tmr.expired &&
        (s_reg.state == eps_pkg::ST_IDLE)) begin
      s_next.flash_on = 1'b0;
    end

    unique case (s_reg.state)
      eps_pkg::ST_IDLE: begin
        s_next.rd = 1'b0;
        s_next.oe = 1'b0;
        s_next.pgm = 1'b0;
      end
      eps_pkg::ST_ADDR: begin
        // Present address, read both sides and let them settle
        s_next.rd = 1'b1;
        s_next.pgm = 1'b0;
        s_next.oe = (s_reg.mode == eps_pkg::MODE_TEST);
        if (s_reg.mode == eps_pkg::MODE_TEST) begin
          s_next.wdata = eps_pkg::TEST_SEED << s_reg.step;
        end
        s_next.tmr_start = 1'b1;
        s_next.tmr_load = 32'(READ_SETTLE_CYC);
        s_next.state = eps_pkg::ST_READ;
      end
      eps_pkg::ST_READ: begin
        if (step_tmr.expired) begin
          if ((s_reg.mode == eps_pkg::MODE_PROG) && !s_reg.written) begin
            // Option bytes and data go in as stored in the image
            s_next.wdata = src_data;
            s_next.pgm = 1'b1;
            s_next.oe = 1'b1;
            s_next.rd = 1'b0;
            s_next.tmr_start = 1'b1;
            s_next.tmr_load = 32'(PGM_PULSE_CYC);
            s_next.state = eps_pkg::ST_PULSE;
          end else begin
            s_next.state = eps_pkg::ST_EVAL;
          end
        end
      end
      eps_pkg::ST_PULSE: begin
        // Programmed byte is read back at once
        if (step_tmr.expired) begin
          s_next.pgm = 1'b0;
          s_next.oe = 1'b0;
          s_next.written = 1'b1;
          s_next.state = eps_pkg::ST_ADDR;
        end
      end
      eps_pkg::ST_EVAL: begin
        s_next.fail = s_reg.fail || bad;
        s_next.written = 1'b0;
        s_next.rd = 1'b0;
        s_next.oe = 1'b0;
        if ((s_reg.mode == eps_pkg::MODE_TEST) ?
            (s_reg.step == eps_pkg::TEST_LAST_STEP) : last_addr) begin
          s_next.done = 1'b1;
          s_next.state = eps_pkg::ST_IDLE;
          ev[eps_pkg::INT_DONE_BIT] = 1'b1;
          ev[eps_pkg::INT_FAIL_BIT] = s_reg.fail || bad;
          if ((s_reg.mode == eps_pkg::MODE_TEST) && (s_reg.fail || bad)) begin
            s_next.flash_on = 1'b1;
            s_next.tmr_start = 1'b1;
            s_next.tmr_load = 32'(FAULT_FLASH_CYC);
          end
        end else begin
          s_next.step = 3'(s_reg.step + 3'h1);
          s_next.addr = addr_step;
          s_next.state = eps_pkg::ST_ADDR;
        end
      end
    endcase

    // A new start abandons whatever runs and clears the held result
    if (go) begin
      s_next.mode = go_mode;
      s_next.addr = eps_pkg::ADDR_OPT_FIRST;
      s_next.step = 3'h0;
      s_next.written = 1'b0;
      s_next.fail = 1'b0;
      s_next.done = 1'b0;
      s_next.flash_on = 1'b0;
      s_next.pgm = 1'b0;
      s_next.oe = 1'b0;
      s_next.state = eps_pkg::ST_ADDR;
    end

    // Indicators: steady on pass, blinking on fail (self test blinks only during the fault flash), dark while busy
    res_lit = s_reg.done && (!s_reg.fail || s_reg.blink);
    s_next.leds = 3'h0;
    unique case (s_reg.mode)
      eps_pkg::MODE_TEST: begin
        if (s_reg.done && (!s_reg.fail || (s_reg.flash_on && s_reg.blink))) begin
          s_next.leds = 3'h7;
        end
      end
      eps_pkg::MODE_BLANK: s_next.leds[0] = res_lit;
      eps_pkg::MODE_PROG: s_next.leds[1] = res_lit;
      eps_pkg::MODE_VERIFY: s_next.leds[2] = res_lit;
    endcase

    // Sticky events, a new event wins over a clear
    s_next.int_stat = (s_reg.int_stat & ~clr) | ev;
    if (apb_wr && (paddr == eps_pkg::REG_INT_EN)) begin
      s_next.int_en = pwdata[1:0];
    end

    // Read data and error prepared in the setup cycle
    if (apb_setup) begin
      s_next.pslverr = 1'b0;
      unique case (paddr)
        eps_pkg::REG_CTRL: s_next.prdata = 32'h0000_0000;
        eps_pkg::REG_STATUS: begin
          s_next.prdata = {15'h0000, s_reg.addr, s_reg.mode, s_reg.fail,
                           s_reg.done, s_reg.flash_on,
                           s_reg.state != eps_pkg::ST_IDLE};
        end
        eps_pkg::REG_INT_STAT: s_next.prdata = {30'h0, s_reg.int_stat};
        eps_pkg::REG_INT_CLR: s_next.prdata = 32'h0000_0000;
        eps_pkg::REG_INT_EN: s_next.prdata = {30'h0, s_reg.int_en};
        default: begin
          s_next.prdata = 32'h0000_0000;
          s_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.state <= eps_pkg::ST_IDLE;
      s_reg.mode <= eps_pkg::MODE_TEST;
      s_reg.addr <= eps_pkg::ADDR_OPT_FIRST;
      s_reg.int_en <= eps_pkg::INT_EN_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready = psel && penable;
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr && psel && penable;
  assign irq = |(s_reg.int_stat & s_reg.int_en);
  assign src_addr = s_reg.addr;
  assign src_rd = s_reg.rd;
  // Program area goes back up by the offset, data space maps straight
  assign tgt_addr = (s_reg.addr >= eps_pkg::ADDR_PROG_FIRST) ?
                    12'({1'b0, s_reg.addr} + eps_pkg::TGT_PROG_OFFSET) :
                    {1'b0, s_reg.addr};
  assign tgt_wdata = s_reg.wdata;
  assign tgt_data_oe = s_reg.oe;
  assign tgt_rd = s_reg.rd;
  assign tgt_pgm = s_reg.pgm;
  assign led_blank = s_reg.leds[0];
  assign led_program = s_reg.leds[1];
  assign led_verify = s_reg.leds[2];

endmodule

`default_nettype wire

// ### eps_socket_model.sv
`timescale 1ns/100ps
`default_nettype none

module eps_socket_model (
  // Clock
  input wire logic pclk,
  // Source EPROM
  input wire logic [10:0] src_addr,
  input wire logic src_rd,
  output logic [7:0] src_data,
  // Target socket
  input wire logic [11:0] tgt_addr,
  input wire logic [7:0] tgt_wdata,
  input wire logic tgt_data_oe,
  input wire logic tgt_rd,
  input wire logic tgt_pgm,
  output logic [7:0] tgt_rdata,
  // Breaks the loopback path
  input wire logic loop_fault
);
  logic [7:0] src_mem [2048];
  logic [7:0] tgt_mem [4096];
  logic [7:0] noise = 8'ha5;
  //////////////////////////////////////////////
  // Released lines wander every cycle
  always @(posedge pclk) begin
    noise <= noise + 8'h5b;
  end
  // Programming only sets bits of a cell
  always @(posedge pclk) begin
    if (tgt_pgm && tgt_data_oe) begin
      tgt_mem[tgt_addr] <= tgt_mem[tgt_addr] | tgt_wdata;
    end
  end
  // Read paths, loopback while driven
  assign src_data = src_rd ? src_mem[src_addr] : noise;
  assign tgt_rdata = tgt_data_oe ? tgt_wdata ^ {7'h00, loop_fault} :
    (tgt_rd ? tgt_mem[tgt_addr] : ~noise);
endmodule

`default_nettype wire

// ### eps_timer.sv
`timescale 1ns/100ps
`default_nettype none

module eps_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control from the sequencer
  eps_tmr_if.tmr t
);

  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic expired;
  } eps_tmr_st_t;

  eps_tmr_st_t s_reg;
  eps_tmr_st_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Expires load plus one cycles after start; start restarts at any time
  always_comb begin
    s_next = s_reg;
    s_next.expired = 1'b0;
    if (t.start) begin
      s_next.cnt = t.load;
      s_next.busy = 1'b1;
    end else if (s_reg.busy) begin
      if (s_reg.cnt <= 32'h0000_0001) begin
        s_next.cnt = 32'h0000_0000;
        s_next.busy = 1'b0;
        s_next.expired = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - 32'h0000_0001;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign t.expired = s_reg.expired;
  assign t.busy = s_reg.busy;

endmodule

`default_nettype wire

// ### eps_tmr_if.sv
`timescale 1ns/100ps
`default_nettype none

// Start and expiry of one down-counting timer
interface eps_tmr_if;
  logic start;
  logic [31:0] load;
  logic expired;
  logic busy;
  modport ctl (output start, output load, input expired, input busy);
  modport tmr (input start, input load, output expired, output busy);
endinterface

`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic mode_select_high = 1'h0;
  logic mode_select_low = 1'h0;
  logic restart_switch = 1'h0;
  logic loop_fault = 1'h0;
  logic [31:0] seed = 32'h509c;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, src_rd, tgt_data_oe, tgt_rd, tgt_pgm, er;
  logic led_blank, led_program, led_verify, inr;
  logic [10:0] src_addr;
  logic [11:0] tgt_addr;
  logic [7:0] src_data, tgt_wdata, tgt_rdata, exp_b;
  logic [5:0] exp_q[$];
  logic [5:0] got;
  logic [2:0] on_m, off_m;
  int err_total = 0;
  int comparisons = 0;
  int graded_n = 0;
  int t;
  //////////////////////////////////////////////
  // Clock
  always #20 pclk = ~pclk;
  eps_sequencer #(.PGM_PULSE_CYC(4), .READ_SETTLE_CYC(4),
    .BLINK_HALF_CYC(8), .FAULT_FLASH_CYC(40)) eps_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .mode_select_high(mode_select_high), .mode_select_low(mode_select_low),
    .restart_switch(restart_switch), .src_addr(src_addr), .src_rd(src_rd),
    .src_data(src_data), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata),
    .tgt_data_oe(tgt_data_oe), .tgt_rd(tgt_rd), .tgt_pgm(tgt_pgm),
    .tgt_rdata(tgt_rdata), .led_blank(led_blank),
    .led_program(led_program), .led_verify(led_verify));
  eps_socket_model sock (.pclk(pclk), .src_addr(src_addr), .src_rd(src_rd),
    .src_data(src_data), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata),
    .tgt_data_oe(tgt_data_oe), .tgt_rd(tgt_rd), .tgt_pgm(tgt_pgm),
    .tgt_rdata(tgt_rdata), .loop_fault(loop_fault));
  // Pseudo random bytes
  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  // Indicator code: dark, steady or blinking
  function automatic logic [1:0] grade(input logic on, input logic off);
    return on ? (off ? 2'h2 : 2'h1) : 2'h0;
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask
  // Bus cycle: setup, then access until pready
  task automatic apb(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Mask, unmask, read and clear the sticky flags
  task automatic settle(input logic f);
    apb(eps_pkg::REG_INT_EN, 1'h1, 32'h0);
    repeat (2) @(negedge pclk);
    check("masked irq", irq, 32'h0);
    apb(eps_pkg::REG_INT_EN, 1'h1, 32'h3);
    repeat (2) @(negedge pclk);
    check("enabled irq", irq, 32'h1);
    apb(eps_pkg::REG_INT_STAT, 1'h0, 32'h0);
    check("int status", rd, {30'h0, f, 1'h1});
    apb(eps_pkg::REG_STATUS, 1'h0, 32'h0);
    check("status", rd & 32'h0000_000d, {28'h0, f, 3'h4});
    apb(eps_pkg::REG_INT_CLR, 1'h1, 32'h3);
    repeat (2) @(negedge pclk);
    check("cleared irq", irq, 32'h0);
  endtask
  // Set the mode, toggle restart or write the start bit, wait for grading
  task automatic run(input logic [1:0] m, input logic [5:0] e,
    input logic by_reg = 1'h0);
    int n0;
    int k;
    n0 = graded_n;
    k = 0;
    exp_q.push_back(e);
    @(posedge pclk);
    {mode_select_high, mode_select_low} <= m;
    if (by_reg) begin
      apb(eps_pkg::REG_CTRL, 1'h1, {29'h0, m, 1'h1});
    end else begin
      @(posedge pclk);
      restart_switch <= 1'h1;
      repeat (3) @(posedge pclk);
      restart_switch <= 1'h0;
    end
    while (graded_n == n0 && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    check("graded", graded_n - n0, 32'h1);
    settle(e[5] | e[3] | e[1]);
  endtask
  // Verdict
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////
  // Grade the indicators once an operation reports completion
  initial begin
    forever begin
      @(posedge irq);
      if (exp_q.size() > 0) begin
        on_m = 3'h0;
        off_m = 3'h0;
        repeat (3) @(negedge pclk);
        repeat (24) begin
          @(negedge pclk);
          on_m = on_m | {led_blank, led_program, led_verify};
          off_m = off_m | ~{led_blank, led_program, led_verify};
        end
        got = {grade(on_m[2], off_m[2]), grade(on_m[1], off_m[1]),
          grade(on_m[0], off_m[0])};
        check("indicators", got, exp_q.pop_front());
        graded_n++;
      end
    end
  end
  // Cut a hang short
  initial begin
    repeat (95000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
  // Main sequence
  initial begin
    for (int a = 0; a < 2048; a++) begin
      sock.src_mem[a] = rnd() | 8'h01;
    end
    for (int a = 0; a < 4096; a++) begin
      sock.tgt_mem[a] = eps_pkg::BLANK_VALUE;
    end
    for (int a = 11'h012; a < 11'h017; a++) begin
      sock.src_mem[a] = sock.src_mem[11'h017];
    end
    sock.src_mem[11'h7fc] = 8'h3c;
    // First byte of an image for the larger part, target 0xc10
    sock.src_mem[11'h410] = 8'h81;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(eps_pkg::REG_INT_EN, 1'h0, 32'h0);
    check("int enable reset", rd, 32'h0);
    apb(8'h14, 1'h0, 32'h0);
    check("unmapped error", er, 32'h1);
    apb(eps_pkg::REG_INT_EN, 1'h1, 32'h3);
    run(2'h0, 6'h15);
    loop_fault <= 1'h1;
    run(2'h0, 6'h2a);
    loop_fault <= 1'h0;
    repeat (40) @(negedge pclk);
    check("flash over", {led_blank, led_program, led_verify}, 32'h0);
    run(2'h0, 6'h15, 1'h1);
    run(2'h1, 6'h10);
    run(2'h2, 6'h04);
    for (int a = 0; a < 2048; a++) begin
      t = (a >= 11'h400) ? a + 12'h800 : a;
      inr = (a >= 11'h012 && a <= 11'h05f) || a >= 11'h7fc ||
        (a >= 11'h400 && a <= 11'h7f7);
      exp_b = inr ? sock.src_mem[a] : 8'h00;
      check("target byte", sock.tgt_mem[t], exp_b);
    end
    @(posedge pclk);
    mode_select_low <= 1'h1;
    repeat (20) @(negedge pclk);
    check("held result", {src_rd, led_program}, 32'h1);
    run(2'h3, 6'h01);
    run(2'h1, 6'h20);
    sock.tgt_mem[12'hffc] = 8'hff;
    run(2'h3, 6'h02);
    run(2'h2, 6'h08);
    check("pending results", exp_q.size(), 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
